//--- rtl/lf_cfg_device.sv
// Configuration port end: command shifter, register file and direct command strobes.
// Assumes the host link pins are asynchronous to mclk.
// Behaviour
// - Host keeps serial clock at or below 2 MHz
// - Data output released while chip select low
// - Chip select high before shifting a command
// - Sixteen-bit word, most significant bit first
// - Serial input sampled on falling clock edge
// - Top two bits: write, read, direct; 10 forbidden
// - Bits 13..8 address registers 0 to 13
// - Last byte is register data
// - Chip select high-low-high abandons the command
// - Direct command uses code only, no data
// - Five direct command codes decoded
// - Wake release clears wake state
// - Signal strength restart resets measurement
// - Oscillator calibration command starts trimming
// - Zero spurious counter clears register 13
// - Factory command restores all register defaults
// - Host then clears main config bits 3:2
// - Write bursts auto-increment the address
// - Read shifts selected register out
// - Continued clocking reads successive registers
// - Strength restart does not end wake
// - Spurious counter increments on missing preamble
//
// Implementation choice: the Wishbone register port.
module lf_cfg_device
  import lf_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  lf_cfg_if.device link,
  input wire logic [7:0] signalStrength,
  input wire logic spuriousEvent,
  input wire logic wakeUp,
  output logic wakeRelease,
  output logic signalStrengthRestart,
  output logic oscCalStart,
  output logic [NUM_REGS*8-1:0] configFlat
);
  typedef enum logic [1:0] {PH_HEAD, PH_DATA, PH_IGNORE} phase_t;

  logic csLevel;
  logic csRise;
  logic csFall;
  logic sclkRise;
  logic sclkFall;
  logic sdLevel;
  phase_t phase_q;
  logic [3:0] bitCnt_q;
  logic [7:0] head_q;
  logic [7:0] data_q;
  logic [1:0] mode_q;
  logic [5:0] addr_q;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] outShift_q;
  logic sdOut_q;
  logic wakeRelease_q;
  logic restart_q;
  logic oscCal_q;
  logic wrStrobe;
  logic dcStrobe;
  logic zeroStrobe;
  logic factoryStrobe;
  logic [7:0] wrByte;
  logic [5:0] dcCode;
  logic [5:0] headAddr;
  logic [5:0] nextAddr;

  function automatic logic [7:0] readReg(input logic [5:0] a, input logic [7:0] strength,
                                         input logic [7:0] cur);
    if (a == ADDR_SIGNAL_STRENGTH) begin
      readReg = strength;
    end else if (a <= ADDR_LAST) begin
      readReg = cur;
    end else begin
      readReg = 8'h00;
    end
  endfunction

  // Data level lags one cycle behind the clock edge strobes; the host sets a bit half a period before its sampling edge
  pin_sync csSync (.mclk(mclk), .srst(srst), .pinIn(link.chipSel),
    .level(csLevel), .rise(csRise), .fall(csFall));
  pin_sync sclkSync (.mclk(mclk), .srst(srst), .pinIn(link.sclk),
    .level(), .rise(sclkRise), .fall(sclkFall));
  pin_sync sdSync (.mclk(mclk), .srst(srst), .pinIn(link.sdIn),
    .level(sdLevel), .rise(), .fall());

  // Command shifter; any chip select change restarts framing
  always_ff @(posedge mclk) begin
    if (srst || csRise || csFall || !csLevel) begin
      phase_q <= PH_HEAD;
      bitCnt_q <= 4'h0;
      head_q <= 8'h00;
      data_q <= 8'h00;
    end else if (sclkFall) begin
      if (phase_q == PH_HEAD) begin
        head_q <= {head_q[6:0], sdLevel};
        bitCnt_q <= bitCnt_q + 4'h1;
        if (bitCnt_q == 4'h7) begin
          bitCnt_q <= 4'h0;
          if (head_q[6:5] == MODE_DIRECT || head_q[6:5] == MODE_BAD) begin
            phase_q <= PH_IGNORE;
          end else begin
            phase_q <= PH_DATA;
          end
        end
      end else if (phase_q == PH_DATA) begin
        data_q <= {data_q[6:0], sdLevel};
        bitCnt_q <= (bitCnt_q == 4'h7) ? 4'h0 : bitCnt_q + 4'h1;
      end
    end
  end

  // Address counter runs past the last register; those bytes read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= MODE_WRITE;
      addr_q <= 6'h00;
    end else if (sclkFall && phase_q == PH_HEAD && bitCnt_q == 4'h7 && csLevel) begin
      mode_q <= head_q[6:5];
      addr_q <= headAddr;
    end else if (sclkFall && phase_q == PH_DATA && bitCnt_q == 4'h7 && csLevel) begin
      addr_q <= addr_q + 6'h01;
    end
  end

  // Address of the command head, and of the next byte in a burst
  assign headAddr = {head_q[4:0], sdLevel};
  assign nextAddr = addr_q + 6'h01;
  assign wrByte = {data_q[6:0], sdLevel};
  assign wrStrobe = sclkFall && csLevel && !csRise && phase_q == PH_DATA &&
                    bitCnt_q == 4'h7 && mode_q == MODE_WRITE;
  assign dcCode = {head_q[4:0], sdLevel};
  assign dcStrobe = sclkFall && csLevel && !csRise && phase_q == PH_HEAD &&
                    bitCnt_q == 4'h7 && head_q[6:5] == MODE_DIRECT;
  assign zeroStrobe = dcStrobe && dcCode == DC_ZERO_SPURIOUS;
  assign factoryStrobe = dcStrobe && dcCode == DC_FACTORY;

  // Register file
  // A write or a clear beats a counter event in the same cycle
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge mclk) begin
        if (srst || factoryStrobe) begin
          regs_q[i] <= RESET_VALUE[i];
        end else if (wrStrobe && addr_q == 6'(i)) begin
          regs_q[i] <= wrByte;
        end else if (i == int'(ADDR_SPURIOUS_WAKEUP_COUNTER) && zeroStrobe) begin
          regs_q[i] <= 8'h00;
        end else if (i == int'(ADDR_SPURIOUS_WAKEUP_COUNTER) && spuriousEvent) begin
          regs_q[i] <= regs_q[i] + 8'h01;
        end
      end
      assign configFlat[i*8 +: 8] = regs_q[i];
    end
  endgenerate

  // Direct command strobes, one cycle each
  always_ff @(posedge mclk) begin
    if (srst) begin
      wakeRelease_q <= 1'b0;
    end else begin
      wakeRelease_q <= dcStrobe && dcCode == DC_WAKE_RELEASE && wakeUp;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= dcStrobe && dcCode == DC_SIGNAL_STRENGTH_RESTART;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      oscCal_q <= 1'b0;
    end else begin
      oscCal_q <= dcStrobe && dcCode == DC_OSC_CAL;
    end
  end

  // Read shifter: load on the address edge, advance on rising edges
  always_ff @(posedge mclk) begin
    if (srst || !csLevel) begin
      outShift_q <= 8'h00;
      sdOut_q <= 1'b0;
    end else if (sclkFall && phase_q == PH_HEAD && bitCnt_q == 4'h7) begin
      outShift_q <= readReg(headAddr, signalStrength,
                            regs_q[headAddr <= ADDR_LAST ?
                                   4'(headAddr) : 4'h0]);
    end else if (sclkFall && phase_q == PH_DATA && bitCnt_q == 4'h7 && mode_q == MODE_READ) begin
      outShift_q <= readReg(nextAddr, signalStrength,
                            regs_q[nextAddr <= ADDR_LAST ?
                                   4'(nextAddr) : 4'h0]);
    end else if (sclkRise && phase_q == PH_DATA && mode_q == MODE_READ) begin
      sdOut_q <= outShift_q[7];
      outShift_q <= {outShift_q[6:0], 1'b0};
    end
  end

  assign link.sdOut = sdOut_q;
  // Enable follows the synchronised select, so release lags the pin by a few cycles
  assign link.sdOutEn = csLevel && phase_q == PH_DATA && mode_q == MODE_READ;
  assign wakeRelease = wakeRelease_q;
  assign signalStrengthRestart = restart_q;
  assign oscCalStart = oscCal_q;
endmodule // lf_cfg_device

//--- rtl/lf_cfg_pkg.sv
// Constants shared by both ends of the serial configuration port.
// Assumes a 100 MHz system clock on each end.
package lf_cfg_pkg;
  localparam int CMD_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam int NUM_REGS = 14;
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_READ = 2'h1;
  localparam logic [1:0] MODE_BAD = 2'h2;
  localparam logic [1:0] MODE_DIRECT = 2'h3;
  localparam logic [5:0] DC_WAKE_RELEASE = 6'h00;
  localparam logic [5:0] DC_SIGNAL_STRENGTH_RESTART = 6'h01;
  localparam logic [5:0] DC_OSC_CAL = 6'h02;
  localparam logic [5:0] DC_ZERO_SPURIOUS = 6'h03;
  localparam logic [5:0] DC_FACTORY = 6'h04;
  localparam logic [5:0] ADDR_MAIN_CONFIG = 6'h00;
  localparam logic [5:0] ADDR_SIGNAL_STRENGTH = 6'h0A;
  localparam logic [5:0] ADDR_SPURIOUS_WAKEUP_COUNTER = 6'h0D;
  localparam logic [5:0] ADDR_LAST = 6'h0D;
  // Factory defaults, registers 0..13
  localparam logic [7:0] RESET_VALUE [NUM_REGS] = '{
    8'h00, 8'h03, 8'h00, 8'h20, 8'h10, 8'h69, 8'h96, 8'h0B,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Host link timing
  localparam int CLK_MHZ = 100;
  localparam int LINK_MAX_KHZ = 2000;
  localparam int SCLK_HALF_CYCLES = (CLK_MHZ * 1000 + 2 * LINK_MAX_KHZ - 1) / (2 * LINK_MAX_KHZ);
  localparam int CS_GAP_CYCLES = SCLK_HALF_CYCLES;
  // Host Wishbone registers, byte addresses
  localparam logic [3:0] WB_CMD = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam logic [3:0] WB_RDATA = 4'h8;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
endpackage : lf_cfg_pkg

//--- rtl/lf_cfg_if.sv
// Link between host and configuration port.
// Assumes the host end qualifies the shared data-out wire with its enable.
interface lf_cfg_if;
  logic chipSel;
  logic sclk;
  logic sdIn;
  logic sdOut;
  logic sdOutEn;
  modport device (input chipSel, input sclk, input sdIn, output sdOut, output sdOutEn);
  modport host (output chipSel, output sclk, output sdIn, input sdOut, input sdOutEn);
endinterface : lf_cfg_if

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser; a change counts when stages two and three agree.
// Assumes an asynchronous input and srst on mclk.
module pin_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] stage_q;
  logic level_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], pinIn};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

  assign level = level_q;
  assign rise = (stage_q[1] == stage_q[2]) && stage_q[2] && !level_q;
  assign fall = (stage_q[1] == stage_q[2]) && !stage_q[2] && level_q;
endmodule // pin_sync

//--- rtl/lf_cfg_host.sv
// Host end: Wishbone slave registers drive a serial master for the configuration port.
// Assumes the device samples data on falling serial clock edges.
module lf_cfg_host
  import lf_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  lf_cfg_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_END_HI, H_END_LO, H_END_HI2} hstate_t;

  hstate_t state_q;
  logic [15:0] shift_q;
  logic [4:0] bitsLeft_q;
  logic [7:0] rdata_q;
  logic [7:0] timer_q;
  logic done_q;
  logic ack_q;
  logic sdoLevel;
  logic start;

  // A released data line reads low
  pin_sync sdoSync (.mclk(mclk), .srst(srst), .pinIn(link.sdOut && link.sdOutEn),
    .level(sdoLevel), .rise(), .fall());

  // A command is taken at the edge that sees ack high, when the master completes
  assign start = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_adr_i == WB_CMD &&
                 wb_sel_i[1:0] == 2'h3 && state_q == H_IDLE && timer_q == 8'h0 &&
                 wb_dat_i[15:14] != MODE_BAD;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_dat_o <= 32'h0;
    end else if (wb_adr_i == WB_STATUS) begin
      wb_dat_o <= {30'h0, done_q, (state_q != H_IDLE || timer_q != 8'h0)};
    end else if (wb_adr_i == WB_RDATA) begin
      wb_dat_o <= {24'h0, rdata_q};
    end else begin
      wb_dat_o <= 32'h0;
    end
  end

  // Serial frame: 16 bits (8 for a direct command), then CS low-high-low
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= H_IDLE;
      timer_q <= 8'h0;
      shift_q <= 16'h0;
      bitsLeft_q <= 5'h0;
      link.chipSel <= 1'b0;
      link.sclk <= 1'b0;
      link.sdIn <= 1'b0;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      if (start) begin
        done_q <= 1'b0;
      end
      if (timer_q != 8'h0) begin
        timer_q <= timer_q - 8'h1;
      end else begin
        case (state_q)
          H_IDLE: begin
            if (start) begin
              link.chipSel <= 1'b1;
              shift_q <= wb_dat_i[15:0];
              bitsLeft_q <= (wb_dat_i[15:14] == MODE_DIRECT) ? 5'h08 : 5'h10;
              timer_q <= 8'(SCLK_HALF_CYCLES);
              state_q <= H_HIGH;
            end
          end
          H_HIGH: begin
            link.sclk <= 1'b1;
            link.sdIn <= shift_q[15];
            shift_q <= {shift_q[14:0], 1'b0};
            timer_q <= 8'(SCLK_HALF_CYCLES);
            state_q <= H_LOW;
          end
          H_LOW: begin
            link.sclk <= 1'b0;
            rdata_q <= {rdata_q[6:0], sdoLevel};
            bitsLeft_q <= bitsLeft_q - 5'h01;
            timer_q <= 8'(SCLK_HALF_CYCLES);
            state_q <= (bitsLeft_q == 5'h01) ? H_END_HI : H_HIGH;
          end
          H_END_HI: begin
            link.chipSel <= 1'b0;
            timer_q <= 8'(CS_GAP_CYCLES);
            state_q <= H_END_LO;
          end
          H_END_LO: begin
            link.chipSel <= 1'b1;
            timer_q <= 8'(CS_GAP_CYCLES);
            state_q <= H_END_HI2;
          end
          default: begin
            link.chipSel <= 1'b0;
            done_q <= 1'b1;
            // Select stays low for a gap before the next command; busy until then
            timer_q <= 8'(CS_GAP_CYCLES);
            state_q <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
endmodule // lf_cfg_host

//--- verif/lf_cfg_assertions.sv
// Concurrent checks on the serial configuration link between host and device.
// Assumes it watches the interface signals on the shared mclk.
module lf_cfg_assertions (
  input wire logic mclk,
  input wire logic srst,
  input wire logic chipSel,
  input wire logic sclk,
  input wire logic sdIn,
  input wire logic sdOut,
  input wire logic sdOutEn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclkD_q;
  logic [7:0] perCnt_q;
  logic [5:0] riseCnt_q;
  wire logic sclkRise;
  assign sclkRise = sclk & ~sclkD_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  always_ff @(posedge mclk) begin
    sclkD_q <= srst ? 1'b0 : sclk;
  end
  // Cycles since the last serial clock rise, saturating
  always_ff @(posedge mclk) begin
    if (srst) begin
      perCnt_q <= 8'hFF;
    end else if (sclkRise) begin
      perCnt_q <= 8'h01;
    end else if (perCnt_q != 8'hFF) begin
      perCnt_q <= perCnt_q + 8'h01;
    end
  end
  // Serial clock rises within one select window
  always_ff @(posedge mclk) begin
    if (srst || !chipSel) begin
      riseCnt_q <= 6'h00;
    end else if (sclkRise) begin
      riseCnt_q <= riseCnt_q + 6'h01;
    end
  end
  property p_cs_release; (!chipSel) [*6] |-> !sdOutEn; endproperty
  property p_en_in_data; $rose(sdOutEn) |-> chipSel && riseCnt_q >= 6'h08; endproperty
  property p_out_after_rise;
    sdOutEn && $past(sdOutEn) && $changed(sdOut) |-> perCnt_q <= 8'h08;
  endproperty
  property p_period; sclkRise |-> perCnt_q >= 8'h32; endproperty
  property p_sclk_in_frame; sclk |-> chipSel; endproperty
  property p_cs_gap; $fell(chipSel) |-> (!chipSel) [*8]; endproperty
  property p_bit_count; $fell(chipSel) |-> riseCnt_q inside {6'h00, 6'h08, 6'h10}; endproperty
  property p_sdin_stable; $fell(sclk) |-> $stable(sdIn) [*4]; endproperty
  a_cs_release: assert property (p_cs_release) else $error("data out driven unselected");
  a_en_in_data: assert property (p_en_in_data) else $error("data out enabled early");
  a_out_after_rise: assert property (p_out_after_rise) else $error("data out moved late");
  a_period: assert property (p_period) else $error("serial clock too fast");
  a_sclk_in_frame: assert property (p_sclk_in_frame) else $error("clock without select");
  a_cs_gap: assert property (p_cs_gap) else $error("select low phase too short");
  a_bit_count: assert property (p_bit_count) else $error("wrong bit count in frame");
  a_sdin_stable: assert property (p_sdin_stable) else $error("data in moved at sample");
  c_read: cover property ($rose(sdOutEn));
  c_direct: cover property ($fell(chipSel) && riseCnt_q == 6'h08);
  c_full: cover property ($fell(chipSel) && riseCnt_q == 6'h10);
endmodule // lf_cfg_assertions

//--- verif/test_lf_wakeup_serial_config_port.sv
// Self-checking bench: Wishbone host end driving the device end over the link.
// Assumes a 100 MHz mclk and synchronous active-high srst for both ends.
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_lf_wakeup_serial_config_port import lf_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h0000_0000;
  logic [31:0] datO;
  logic ack;
  logic [7:0] signalStrength = 8'h00;
  logic spuriousEvent = 1'b0;
  logic wakeUp = 1'b0;
  logic wakeRelease, signalStrengthRestart, oscCalStart;
  logic [NUM_REGS*8-1:0] configFlat;
  int miscompares = 0;
  int cmp_count = 0;
  int nWake = 0;
  int nRss = 0;
  int nOsc = 0;
  lf_cfg_if link();
  lf_cfg_host i_lf_cfg_host (.mclk(mclk), .srst(srst), .link(link), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack));
  lf_cfg_device i_lf_cfg_device (.mclk(mclk), .srst(srst), .link(link),
    .signalStrength(signalStrength), .spuriousEvent(spuriousEvent), .wakeUp(wakeUp),
    .wakeRelease(wakeRelease), .signalStrengthRestart(signalStrengthRestart),
    .oscCalStart(oscCalStart), .configFlat(configFlat));
  lf_cfg_assertions i_lf_cfg_assertions (.mclk(mclk), .srst(srst), .chipSel(link.chipSel),
    .sclk(link.sclk), .sdIn(link.sdIn), .sdOut(link.sdOut), .sdOutEn(link.sdOutEn));
  always #5 mclk = ~mclk;
  // Strobe pulse counters
  always @(posedge mclk) begin
    if (wakeRelease === 1'b1) nWake++;
    if (signalStrengthRestart === 1'b1) nRss++;
    if (oscCalStart === 1'b1) nOsc++;
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= 4'hF;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      give_verdict;
    end
  endtask
  task automatic sendCmd(input logic [15:0] word);
    logic [31:0] q;
    int n;
    n = 0;
    wbXfer(1'b1, WB_CMD, {16'h0000, word}, q);
    do begin
      wbXfer(1'b0, WB_STATUS, 32'h0000_0000, q);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      miscompares++;
      give_verdict;
    end
  endtask
  task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
    sendCmd({MODE_WRITE, a, d});
  endtask
  task automatic rdReg(input logic [5:0] a, output logic [7:0] v);
    logic [31:0] q;
    sendCmd({MODE_READ, a, 8'h00});
    wbXfer(1'b0, WB_RDATA, 32'h0000_0000, q);
    v = q[7:0];
  endtask
  task automatic checkDefaults;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i != 10) `CHK(configFlat[8*i +: 8], RESET_VALUE[i])
    end
  endtask
  task automatic t_reset;
    logic [7:0] v;
    checkDefaults;
    rdReg(6'h05, v);
    `CHK(v, RESET_VALUE[5])
    rdReg(ADDR_SPURIOUS_WAKEUP_COUNTER, v);
    `CHK(v, 8'h00)
    $display("test reset done");
  endtask
  task automatic t_rw;
    logic [7:0] v;
    logic [NUM_REGS*8-1:0] keep;
    signalStrength <= 8'h5A;
    wrReg(6'h03, 8'hA5);
    `CHK(configFlat[8*3 +: 8], 8'hA5)
    rdReg(6'h03, v);
    `CHK(v, 8'hA5)
    wrReg(ADDR_LAST, 8'h7E);
    `CHK(configFlat[8*13 +: 8], 8'h7E)
    rdReg(ADDR_SIGNAL_STRENGTH, v);
    `CHK(v, 8'h5A)
    keep = configFlat;
    wrReg(6'h23, 8'h3C);
    `CHK(configFlat, keep)
    rdReg(6'h23, v);
    `CHK(v, 8'h00)
    $display("test read write done");
  endtask
  task automatic t_direct;
    int w, r, o;
    w = nWake;
    r = nRss;
    o = nOsc;
    wakeUp <= 1'b1;
    wrReg(ADDR_LAST, 8'h00);
    repeat (3) begin
      @(posedge mclk) spuriousEvent <= 1'b1;
      @(posedge mclk) spuriousEvent <= 1'b0;
    end
    @(posedge mclk);
    `CHK(configFlat[8*13 +: 8], 8'h03)
    sendCmd({MODE_DIRECT, DC_SIGNAL_STRENGTH_RESTART, 8'h00});
    `CHK(nRss - r, 1)
    `CHK(nWake - w, 0)
    sendCmd({MODE_DIRECT, DC_OSC_CAL, 8'h00});
    `CHK(nOsc - o, 1)
    sendCmd({MODE_DIRECT, DC_WAKE_RELEASE, 8'h00});
    `CHK(nWake - w, 1)
    wakeUp <= 1'b0;
    sendCmd({MODE_DIRECT, DC_WAKE_RELEASE, 8'h00});
    `CHK(nWake - w, 1)
    sendCmd({MODE_DIRECT, DC_ZERO_SPURIOUS, 8'h00});
    `CHK(configFlat[8*13 +: 8], 8'h00)
    wrReg(6'h03, 8'h5A);
    wrReg(ADDR_LAST, 8'h44);
    sendCmd({MODE_DIRECT, DC_FACTORY, 8'h00});
    checkDefaults;
    wrReg(ADDR_MAIN_CONFIG, 8'h00);
    `CHK(nRss - r + nOsc - o, 2)
    $display("test direct commands done");
  endtask
  task automatic t_refused;
    logic [31:0] q;
    logic [NUM_REGS*8-1:0] keep;
    keep = configFlat;
    sendCmd({MODE_BAD, 6'h03, 8'h11});
    `CHK(configFlat, keep)
    wbXfer(1'b0, 4'hC, 32'h0000_0000, q);
    `CHK(configFlat, keep)
    $display("test refused done");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_rw;
    t_direct;
    t_refused;
    give_verdict;
  end
endmodule // test_lf_wakeup_serial_config_port
